// ### hdl/tac_batch_timer.v
// Purpose: Batch time-delay pacing of automatically triggered sample-set scans
// Assumes: Scan start and set-done pulses come from the sequencer on sys_clk
// Notes: Delay length is selector times one unit; a zero selector adds no delay
`include "tac_regs.vh"
`default_nettype none

module tac_batch_timer #(
  parameter CNT_W = 20,
  parameter [31:0] BATCH_UNIT_CYC = `TAC_BATCH_UNIT_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Control
  input wire [2:0] batchDelaySel,
  input wire scanStart,
  input wire setDone,
  input wire penTouch,
  // Status
  output wire nextSetStart,
  output wire batchWaiting
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;

  reg [1:0] state_reg;
  reg [CNT_W-1:0] delayCnt_reg;
  reg nextSet_reg;
  reg waiting_reg;
  wire [31:0] periodFull;
  wire [CNT_W-1:0] periodCyc;
  wire expired;

  // Zero selector gives zero period, so while the pen is down each set follows the last back to back
  assign periodFull = {29'h0, batchDelaySel} * BATCH_UNIT_CYC;
  assign periodCyc = periodFull[CNT_W-1:0];
  assign expired = (delayCnt_reg == {CNT_W{1'b0}});

  // Delay counter and scan pacing state machine
  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      delayCnt_reg <= {CNT_W{1'b0}};
      nextSet_reg <= 1'b0;
      waiting_reg <= 1'b0;
    end else begin
      nextSet_reg <= 1'b0;
      if (!expired) begin
        delayCnt_reg <= delayCnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      case (state_reg)
        ST_IDLE: begin
          // Delay starts with the touch that launches the scan
          if (scanStart) begin
            delayCnt_reg <= periodCyc;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (setDone) begin
            if (expired) begin
              // Accrual time beat the delay: go on at once
              if (penTouch) begin
                nextSet_reg <= 1'b1;
                delayCnt_reg <= periodCyc;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              state_reg <= ST_HOLD;
              waiting_reg <= 1'b1;
            end
          end
        end
        ST_HOLD: begin
          // Touch is judged only at the moment the delay runs out
          if (expired) begin
            waiting_reg <= 1'b0;
            if (penTouch) begin
              nextSet_reg <= 1'b1;
              delayCnt_reg <= periodCyc;
              state_reg <= ST_RUN;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          waiting_reg <= 1'b0;
        end
      endcase
    end
  end

  assign nextSetStart = nextSet_reg;
  assign batchWaiting = waiting_reg;

endmodule

`default_nettype wire

// ### hdl/tac_config_regs.v
// Purpose: Configuration registers and their control effects for a touch converter
// Assumes: Serial bus front end decodes words onto the register port on sys_clk
// Notes: Pen touch level arrives from the analog side and is synchronised here
// Notes: Reserved bits of the batch register have no flops and read as zero
`include "tac_regs.vh"
`default_nettype none

module tac_config_regs #(
  parameter CNT_W = 20,
  parameter [31:0] BATCH_UNIT_CYC = `TAC_BATCH_UNIT_CYC,
  parameter [7:0] NORMAL_SAMPLE_CYC = `TAC_NORMAL_SAMPLE_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register port
  input wire regWrEn,
  input wire regRdEn,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  output wire [15:0] regRdData,
  output wire regRdValid,
  // Sequencer handshake
  input wire hostWait,
  input wire dataAvailIn,
  input wire sampleStart,
  input wire scanStart,
  input wire setDone,
  output wire sampleActive,
  output wire nextSetStart,
  output wire batchWaiting,
  // Analog side and pins
  input wire penTouchRaw,
  output wire touchSenseEn,
  output wire penIrqDataAvail
);

  // Header values are plain integers; cut them to the widths that carry them
  localparam integer LONG_SAMPLE_INT = `TAC_LONG_SAMPLE_CYC;
  localparam [7:0] LONG_SAMPLE_CYC = LONG_SAMPLE_INT[7:0];
  localparam [15:0] CFG1_RESET_WORD = `TAC_CFG1_RESET;
  localparam [2:0] BTD_RESET = CFG1_RESET_WORD[`TAC_BTD_MSB:`TAC_BTD_LSB];
  // Long phase length is fixed by parameters, so it costs no adder at run time
  localparam [7:0] LONG_PHASE_CYC = NORMAL_SAMPLE_CYC + LONG_SAMPLE_CYC;

  // Configuration storage
  // Only the selector of the batch register has flops; reserved bits keep none
  reg [15:0] cfg0_reg;
  reg [2:0] batchDelaySel_reg;
  // Read path
  reg [15:0] rdData_reg;
  reg [15:0] rdData_next;
  reg rdValid_reg;
  // Pen touch synchroniser
  reg penSync1_reg;
  reg penSync2_reg;
  // Sampling phase
  reg [7:0] sampleCnt_reg;
  reg [7:0] sampleLen_next;
  reg sampleActive_reg;
  // Pin side flops and the irq pin's next value
  reg touchSense_reg;
  reg penIrq_reg;
  reg penIrq_next;

  wire longSampleEn;
  wire waitTouchDetectEn;
  wire waitActive;
  wire cfg0Hit;
  wire cfg1Hit;
  wire cfg0Wr;
  wire cfg1Wr;
  wire [15:0] cfg1Word;

  // Field taps and address decode
  assign longSampleEn = cfg0_reg[`TAC_LSM_BIT];
  assign waitTouchDetectEn = cfg0_reg[`TAC_WTD_BIT];
  assign cfg0Hit = (regAddr == `TAC_CFG0_ADDR);
  assign cfg1Hit = (regAddr == `TAC_CFG1_ADDR);

  // Write strobes qualified by address, so a read never disturbs a register
  assign cfg0Wr = regWrEn & cfg0Hit;
  assign cfg1Wr = regWrEn & cfg1Hit;

  // Background detection window: enabled and the device is waiting for the host
  assign waitActive = waitTouchDetectEn & hostWait;

  // Batch register as a read sees it; upper bits tied low
  assign cfg1Word = {13'h0000, batchDelaySel_reg};

  // Register writes; main register bits not handled here are still stored for readback
  always @(posedge sys_clk) begin
    if (rst) begin
      cfg0_reg <= `TAC_CFG0_RESET;
      batchDelaySel_reg <= BTD_RESET;
    end else begin
      if (cfg0Wr) begin
        cfg0_reg <= regWrData;
      end
      if (cfg1Wr) begin
        // Reserved bits are dropped, so a careless write cannot disturb them
        batchDelaySel_reg <= regWrData[`TAC_BTD_MSB:`TAC_BTD_LSB];
      end
    end
  end

  // Read mux; unmapped addresses answer zero
  always @* begin
    rdData_next = 16'h0000;
    if (cfg0Hit) begin
      rdData_next = cfg0_reg;
    end else if (cfg1Hit) begin
      // Upper bits held at zero keeps read-modify-write safe
      rdData_next = cfg1Word;
    end
  end

  // Read data is held until the next read
  // Valid is registered beside the data so both land on the same edge
  always @(posedge sys_clk) begin
    if (rst) begin
      rdData_reg <= 16'h0000;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= regRdEn;
      if (regRdEn) begin
        rdData_reg <= rdData_next;
      end
    end
  end

  // Two-flop synchroniser for the analog touch comparator
  // Only the second flop is read anywhere, so a metastable first stage never spreads
  always @(posedge sys_clk) begin
    if (rst) begin
      penSync1_reg <= 1'b0;
      penSync2_reg <= 1'b0;
    end else begin
      penSync1_reg <= penTouchRaw;
      penSync2_reg <= penSync1_reg;
    end
  end

  // Sampling length picked once per conversion, at its start
  // Limitation: a change of the long-sampling bit mid-phase counts from the next start
  always @* begin
    sampleLen_next = NORMAL_SAMPLE_CYC;
    if (longSampleEn) begin
      sampleLen_next = LONG_PHASE_CYC;
    end
  end

  // Sampling phase counter; a start mid-phase restarts the phase
  // The count reloads on every start, so a retriggered phase is never cut short
  always @(posedge sys_clk) begin
    if (rst) begin
      sampleCnt_reg <= 8'h00;
      sampleActive_reg <= 1'b0;
    end else if (sampleStart) begin
      sampleCnt_reg <= sampleLen_next - 8'h01;
      sampleActive_reg <= 1'b1;
    end else if (sampleCnt_reg != 8'h00) begin
      sampleCnt_reg <= sampleCnt_reg - 8'h01;
    end else begin
      sampleActive_reg <= 1'b0;
    end
  end

  // Pen irq pin: no-touch shows high during the host wait when enabled,
  // which lets the host poll instead of sending a doomed convert
  always @* begin
    penIrq_next = dataAvailIn;
    if (waitActive) begin
      penIrq_next = ~penSync2_reg;
    end
  end

  // Background sensing runs only while waiting for the host
  always @(posedge sys_clk) begin
    if (rst) begin
      touchSense_reg <= 1'b0;
      penIrq_reg <= 1'b0;
    end else begin
      touchSense_reg <= waitActive;
      penIrq_reg <= penIrq_next;
    end
  end

  // Batch delay pacing of automatic sample-set scans
  // Timer judges the synchronised touch, the same level the pin reports
  tac_batch_timer #(
    .CNT_W(CNT_W),
    .BATCH_UNIT_CYC(BATCH_UNIT_CYC)
  ) batchTimer (
    .sys_clk(sys_clk),
    .rst(rst),
    .batchDelaySel(batchDelaySel_reg),
    .scanStart(scanStart),
    .setDone(setDone),
    .penTouch(penSync2_reg),
    .nextSetStart(nextSetStart),
    .batchWaiting(batchWaiting)
  );

  assign regRdData = rdData_reg;
  assign regRdValid = rdValid_reg;
  assign sampleActive = sampleActive_reg;
  assign touchSenseEn = touchSense_reg;
  assign penIrqDataAvail = penIrq_reg;

endmodule

`default_nettype wire

// ### hdl/tac_regs.vh
// Purpose: Shared constants for the touch converter configuration block
// Assumes: Word-wide register port, 20 MHz system clock
// Notes: Offsets, field positions, reset values and timing counts live here
`ifndef TAC_REGS_VH
`define TAC_REGS_VH

// Register addresses on the word port
`define TAC_CFG0_ADDR 4'hc
`define TAC_CFG1_ADDR 4'hd

// Reset values
`define TAC_CFG0_RESET 16'h0000
`define TAC_CFG1_RESET 16'h0000

// Main configuration register fields
`define TAC_LSM_BIT 0
`define TAC_WTD_BIT 1

// Batch delay configuration register fields
`define TAC_BTD_LSB 0
`define TAC_BTD_MSB 2
`define TAC_CFG1_RSVD_LSB 3
`define TAC_CFG1_RSVD_MSB 15

// Clock and timing
`define TAC_CLK_PERIOD_NS 50
`define TAC_LONG_SAMPLE_NS 500
// Least time, so round up to whole cycles
`define TAC_LONG_SAMPLE_CYC ((`TAC_LONG_SAMPLE_NS + `TAC_CLK_PERIOD_NS - 1) / `TAC_CLK_PERIOD_NS)
// Normal sampling phase length in cycles
`define TAC_NORMAL_SAMPLE_CYC 8
// One batch delay unit: 1 ms, which gives 1000 sample sets per second
`define TAC_BATCH_UNIT_US 1000
`define TAC_BATCH_UNIT_CYC ((`TAC_BATCH_UNIT_US * 1000) / `TAC_CLK_PERIOD_NS)

`endif

// ### verification/tac_cfg_checker.sv
// Purpose: Port assertions for the touch converter config block
// Assumes: One sys_clk domain, synchronous active-high rst
// Notes: Field shadows are rebuilt from the write port
`include "tac_regs.vh"
`default_nettype none
module tac_cfg_checker (
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid,
  // Sequencer and pins
  input wire logic hostWait,
  input wire logic dataAvailIn,
  input wire logic sampleActive,
  input wire logic nextSetStart,
  input wire logic batchWaiting,
  input wire logic penTouchRaw,
  input wire logic touchSenseEn,
  input wire logic penIrqDataAvail
);
  logic lsmReg, wtdReg;
  logic [2:0] selReg;
  logic [4:0] actCnt;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Shadows avoid peeking into the design hierarchy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {wtdReg, lsmReg} <= 2'h0;
      selReg <= 3'h0;
    end else if (regWrEn && regAddr == `TAC_CFG0_ADDR) begin
      {wtdReg, lsmReg} <= regWrData[1:0];
    end else if (regWrEn && regAddr == `TAC_CFG1_ADDR) begin
      selReg <= regWrData[2:0];
    end
  end
  // Length of the current sampling run; an unrestarted run peaks at 18, below the 5-bit wrap at 32
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      actCnt <= 5'h00;
    end else begin
      actCnt <= sampleActive ? actCnt + 5'h01 : 5'h00;
    end
  end
  rd_answer_a: assert property (regRdEn |=> regRdValid)
    else $error("read not answered");
  rsvd_zero_a: assert property (regRdEn && regAddr == `TAC_CFG1_ADDR |=>
    regRdData[15:3] == 13'h0000) else $error("reserved bits read nonzero");
  sel_read_a: assert property (regRdEn && regAddr == `TAC_CFG1_ADDR |=>
    regRdData[2:0] == $past(selReg)) else $error("selector readback wrong");
  sense_en_a: assert property (wtdReg && hostWait |=> touchSenseEn)
    else $error("touch sensing not enabled");
  pin_idle_a: assert property ((wtdReg && hostWait && !penTouchRaw) [*4] |=>
    penIrqDataAvail) else $error("pin low with no touch");
  pin_follow_a: assert property (!wtdReg |=> penIrqDataAvail == $past(dataAvailIn))
    else $error("pin not following data flag");
  sample_norm_a: assert property ($fell(sampleActive) && !lsmReg |-> actCnt == 5'h08)
    else $error("normal sampling length wrong");
  sample_long_a: assert property ($fell(sampleActive) && lsmReg |-> actCnt == 5'h12)
    else $error("long sampling length wrong");
  zero_nowait_a: assert property (selReg == 3'h0 |-> !batchWaiting)
    else $error("waiting with zero delay");
  next_pulse_a: assert property (nextSetStart |=> !nextSetStart)
    else $error("next set start not a pulse");
endmodule
bind tac_config_regs tac_cfg_checker chk_u (.sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .regRdValid(regRdValid), .hostWait(hostWait), .dataAvailIn(dataAvailIn),
  .sampleActive(sampleActive), .nextSetStart(nextSetStart), .batchWaiting(batchWaiting),
  .penTouchRaw(penTouchRaw), .touchSenseEn(touchSenseEn), .penIrqDataAvail(penIrqDataAvail));
`default_nettype wire

// ### verification/tac_host_model.sv
// Purpose: Host model that polls the pen pin before converting
// Assumes: Pin sampled on sys_clk while the host waits
// Notes: Convert is held back while the pin reads high
`default_nettype none
module tac_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host side
  input wire logic waitReq,
  input wire logic penIrqDataAvail,
  output logic hostWait,
  output logic convIssued
);
  // High pin means no touch, so polling continues
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hostWait <= 1'b0;
      convIssued <= 1'b0;
    end else begin
      hostWait <= waitReq;
      convIssued <= convIssued | (hostWait & ~penIrqDataAvail);
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the touch converter config block
// Assumes: Word register port, 20 MHz clock
// Notes: Batch unit cut to 20 cycles to keep delay runs short
`include "tac_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UNIT = 20;
  logic sysClk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic waitReq = 1'b0, dataAvailIn = 1'b1, sampleStart = 1'b0;
  logic scanStart = 1'b0, setDone = 1'b0, penTouchRaw = 1'b0, seen;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic regRdValid, sampleActive, nextSetStart, batchWaiting;
  logic touchSenseEn, penIrqDataAvail, hostWait, convIssued;
  int failCount = 0, checkCount = 0, cyc = 0, n;
  tac_config_regs #(.BATCH_UNIT_CYC(UNIT)) dut_u (.sys_clk(sysClk), .rst(rst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .hostWait(hostWait),
    .dataAvailIn(dataAvailIn), .sampleStart(sampleStart), .scanStart(scanStart),
    .setDone(setDone), .sampleActive(sampleActive), .nextSetStart(nextSetStart),
    .batchWaiting(batchWaiting), .penTouchRaw(penTouchRaw),
    .touchSenseEn(touchSenseEn), .penIrqDataAvail(penIrqDataAvail));
  tac_host_model host_u (.sys_clk(sysClk), .rst(rst), .waitReq(waitReq),
    .penIrqDataAvail(penIrqDataAvail), .hostWait(hostWait), .convIssued(convIssued));
  always #25 sysClk = ~sysClk;
  // Hang guard; the run needs well under this
  always @(posedge sysClk) begin
    cyc++;
    if (cyc == 3000) begin
      failCount++;
      testDone();
    end
  end
  task automatic testDone();
    $display("Checks %0d, mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chkW(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkB(input logic got, input logic exp);
    chkW({15'h0000, got}, {15'h0000, exp});
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge sysClk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    pulse(regWrEn);
    tick(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    regAddr = a;
    pulse(regRdEn);
    chkB(regRdValid, 1'b1);
    chkW(regRdData, exp);
    tick(1);
  endtask
  task automatic samp(input int exp);
    pulse(sampleStart);
    n = 0;
    while (sampleActive === 1'b1 && n < 40) begin
      n++;
      tick(1);
    end
    chkW(16'(n), 16'(exp));
  endtask
  // Scan with touch, then a set at expiry without touch must not start
  task automatic batch(input logic [2:0] sel);
    wr(`TAC_CFG1_ADDR, {13'h0000, sel});
    penTouchRaw = 1'b1;
    tick(3);
    pulse(scanStart);
    pulse(setDone);
    chkB(batchWaiting, |sel);
    n = 1;
    while (nextSetStart !== 1'b1 && n < 80) begin
      n++;
      tick(1);
    end
    chkB(n >= sel * UNIT && n <= sel * UNIT + 2, 1'b1);
    penTouchRaw = 1'b0;
    tick(3);
    pulse(setDone);
    seen = 1'b0;
    repeat (50) begin
      seen |= nextSetStart;
      tick(1);
    end
    chkB(seen, 1'b0);
  endtask
  initial begin
    tick(4);
    rst = 1'b0;
    rd(`TAC_CFG0_ADDR, 16'h0000);
    rd(`TAC_CFG1_ADDR, 16'h0000);
    wr(`TAC_CFG1_ADDR, 16'h0007);
    rd(`TAC_CFG1_ADDR, 16'h0007);
    rd(4'h3, 16'h0000);
    wr(`TAC_CFG0_ADDR, 16'h0001);
    rd(`TAC_CFG0_ADDR, 16'h0001);
    // Outside the wait window the pin must track the data-available flag
    dataAvailIn = 1'b0;
    tick(2);
    chkB(penIrqDataAvail, 1'b0);
    dataAvailIn = 1'b1;
    samp(`TAC_NORMAL_SAMPLE_CYC + `TAC_LONG_SAMPLE_CYC);
    wr(`TAC_CFG0_ADDR, 16'h0002);
    samp(`TAC_NORMAL_SAMPLE_CYC);
    waitReq = 1'b1;
    tick(6);
    chkB(touchSenseEn, 1'b1);
    chkB(penIrqDataAvail, 1'b1);
    chkB(convIssued, 1'b0);
    penTouchRaw = 1'b1;
    tick(5);
    chkB(penIrqDataAvail, 1'b0);
    chkB(convIssued, 1'b1);
    waitReq = 1'b0;
    tick(3);
    chkB(touchSenseEn, 1'b0);
    for (int s = 0; s < 3; s++) begin
      batch(3'(s));
    end
    testDone();
  end
endmodule
`default_nettype wire
